/* File: dv/mseq_console_model.sv */
`timescale 1ns/1ps
module mseq_console_model (
    // clock
    input  wire        mclk,
    // request
    output reg         idStrobe,
    output reg  [5:0]  idAddr,
    output reg         idWrite,
    output reg  [31:0] idDataIn,
    // answer
    input  wire [31:0] idDataOut_q,
    input  wire        idDataValid_q
);
    // idle bus at time zero
    initial {idStrobe, idWrite, idAddr, idDataIn} = 40'h0;
    // one-clock request; released address and data lines show flipped values, write line keeps its level
    task req(input [5:0] a, input w, input [31:0] d);
        @(negedge mclk);
        idStrobe = 1'b1;
        idAddr   = a;
        idWrite  = w;
        idDataIn = d;
        @(negedge mclk);
        idStrobe = 1'b0;
        idAddr   = ~a;
        idDataIn = ~d;
    endtask
    // read, answer taken in the one cycle it stands
    task rd(input [5:0] a, output v, output [31:0] q);
        req(a, 1'b0, 32'h0);
        @(negedge mclk);
        v = idDataValid_q;
        q = idDataOut_q;
    endtask
endmodule // mseq_console_model

/* File: dv/mseq_next_address_sva.sv */
`timescale 1ns/1ps
module mseq_next_address_sva (
    // clock and reset
    input wire        mclk,
    input wire        resetn,
    // watched ports
    input wire        idStrobe,
    input wire [5:0]  idAddr,
    input wire        idWrite,
    input wire [31:0] idDataIn,
    input wire [31:0] idDataOut_q,
    input wire        idDataValid_q,
    input wire        csWrEn_q,
    input wire [31:0] csWrData_q,
    input wire        powerGood,
    input wire        consoleForceNoopN,
    input wire [12:0] microPc_q,
    input wire        muxOutEnable_q,
    input wire        latchClosed_q,
    input wire        clearMicroWord_q,
    input wire        abortCycle_q
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    // bus answers
    AST_RD_BREAK: assert property (idStrobe && !idWrite && idAddr == 6'h21
        |-> ##2 idDataValid_q && idDataOut_q[31:13] == 19'h0) else $error("break read");
    AST_RD_DATA: assert property (idStrobe && !idWrite && idAddr == 6'h23
        |-> ##2 idDataValid_q && idDataOut_q[31:8] == 24'h0) else $error("data read");
    AST_UNMAPPED: assert property (idStrobe && idAddr[5:2] != 4'h8
        |-> ##2 !idDataValid_q) else $error("unmapped answer");
    AST_WR_PULSE: assert property (csWrEn_q |-> $past(idStrobe, 1) && $past(idWrite, 1)
        && $past(idAddr, 1) == 6'h23 && csWrData_q == $past(idDataIn, 1)) else $error("write");
    // sequencer
    AST_NOOP: assert property (!consoleForceNoopN [*4]
        |-> clearMicroWord_q && abortCycle_q) else $error("no-op");
    AST_INIT: assert property (!powerGood [*8] ##1 !powerGood [*8] ##1 !powerGood [*8]
        ##1 !powerGood [*8] ##1 !powerGood [*8] |-> microPc_q[11:0] == 12'h100) else $error("init");
    AST_MUX_WIN: assert property ($rose(muxOutEnable_q) |-> muxOutEnable_q [*8]
        ##1 muxOutEnable_q ##1 muxOutEnable_q ##1 !muxOutEnable_q) else $error("mux window");
    AST_LATCH: assert property ($fell(muxOutEnable_q) |-> latchClosed_q) else $error("latch");
    // main scenarios reached
    cover property (csWrEn_q);
    cover property (idDataValid_q);
    cover property (clearMicroWord_q && abortCycle_q && powerGood);
endmodule // mseq_next_address_sva

bind mseq_next_address mseq_next_address_sva u_sva (.*);

/* File: dv/mseq_next_address_tb.sv */
`timescale 1ns/1ps
module mseq_next_address_tb;
    // stimulus and observed signals
    reg         mclk, resetn, powerGood, microTrap, initRequest, cacheStall, patchRequest, v;
    reg         consoleBreakEnable, consoleContinue, consoleMaintReturnN, consoleTrapToWritable;
    reg         consoleForceNoopN;
    reg  [79:0] controlWord;
    reg  [31:0] q;
    reg  [12:0] decisionPointAddr;
    reg  [7:0]  csPresence;
    reg  [5:0]  patchAddr;
    reg  [4:0]  branchCond;
    reg  [3:0]  trapVector;
    wire        idStrobe, idWrite, idDataValid_q, muxOutEnable_q, latchClosed_q, csWrEn_q;
    wire        clearMicroWord_q, abortCycle_q, breakMatch_q, scopeSync_q, clockStopped_q;
    wire [31:0] idDataIn, idDataOut_q, csWrData_q;
    wire [12:0] microPc_q, microPcSave_q, csWrAddr_q;
    wire [5:0]  idAddr;
    wire [1:0]  csWrGroup_q;
    integer     err_count, check_count;

    mseq_next_address  u_dut (.*);
    mseq_console_model u_con (.*);

    // clock
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // compare and count
    task chk(input [32:0] got, input [32:0] exp);
        check_count = check_count + 1;
        if (got !== exp)
        begin
            err_count = err_count + 1;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // verdict
    task wrap_up;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // step to just after the mux window closes
    task phase16;
        wait (muxOutEnable_q);
        @(negedge muxOutEnable_q);
        @(negedge mclk);
    endtask

    // bad power pins the init vector, good power lets the jump through
    task t_power;
        repeat (60) @(negedge mclk);
        chk(microPc_q, 13'h0100);
        powerGood = 1'b1;
        repeat (80) @(negedge mclk);
        chk(microPc_q, 13'h0123);
    endtask

    // trap steered to writable store
    task t_trap;
        consoleTrapToWritable = 1'b1;
        phase16;
        microTrap = 1'b1;
        phase16;
        microTrap = 1'b0;
        chk(microPc_q, 13'h1105);
        chk(microPcSave_q, 13'h0123);
        consoleTrapToWritable = 1'b0;
    endtask

    // console no-op forces clear and abort
    task t_noop;
        consoleForceNoopN = 1'b0;
        repeat (25) @(negedge mclk);
        chk({clearMicroWord_q, abortCycle_q}, 2'h3);
        consoleForceNoopN = 1'b1;
        repeat (25) @(negedge mclk);
        chk({clearMicroWord_q, abortCycle_q}, 2'h0);
    endtask

    // widths, presence, unmapped, load-only count
    task t_regs;
        u_con.req(6'h21, 1'b1, 32'hFFFF_FFFF);
        u_con.rd(6'h21, v, q);
        chk({v, q}, {1'b1, 32'h0000_1FFF});
        u_con.rd(6'h23, v, q);
        chk({v, q}, {1'b1, 32'h0000_00A5});
        u_con.rd(6'h24, v, q);
        chk(v, 1'b0);
        u_con.req(6'h22, 1'b1, 32'h0000_FFFF);
        u_con.req(6'h23, 1'b1, 32'h1234_5678);
        chk(csWrEn_q, 1'b0);
        u_con.rd(6'h22, v, q);
        chk({v, q}, {1'b1, 32'h0000_FFFF});
    endtask

    // four data writes, the wrap bumps the address
    task t_wcs;
        integer i;
        u_con.req(6'h22, 1'b1, 32'h0000_0FFE);
        for (i = 0; i < 4; i = i + 1)
        begin
            u_con.req(6'h23, 1'b1, 32'hC0DE_0000 + i);
            chk({csWrEn_q, csWrGroup_q, csWrAddr_q},
                {1'b1, 2'(i % 3), 13'h0FFE + 13'(i / 3)});
            chk(csWrData_q, 32'hC0DE_0000 + i);
        end
        u_con.rd(6'h22, v, q);
        chk({v, q}, {1'b1, 32'h0000_4FFF});
    endtask

    // pushes then pops on later cycles, last in first out
    task t_stack;
        phase16;
        u_con.req(6'h20, 1'b1, 32'h0000_BEEF);
        u_con.req(6'h20, 1'b1, 32'h0000_1234);
        phase16;
        u_con.rd(6'h20, v, q);
        chk({v, q}, {1'b1, 32'h0000_1234});
        phase16;
        u_con.rd(6'h20, v, q);
        chk({v, q}, {1'b1, 32'h0000_BEEF});
    endtask

    // break stops the clock; maint return then takes the stack top, bus push held off
    task t_break;
        phase16;
        u_con.req(6'h21, 1'b1, 32'h0000_0123);
        u_con.req(6'h20, 1'b1, 32'h0000_0456);
        phase16;
        chk({breakMatch_q, scopeSync_q}, 2'h3);
        consoleBreakEnable = 1'b1;
        wait (clockStopped_q);
        @(negedge mclk);
        chk({breakMatch_q, clockStopped_q}, 2'h3);
        consoleMaintReturnN = 1'b0;
        repeat (4) @(negedge mclk);
        u_con.req(6'h20, 1'b1, 32'h0000_0789);
        {consoleContinue, consoleBreakEnable} = 2'h2;
        phase16;
        chk({clockStopped_q, microPc_q}, {1'b0, 13'h0456});
        {consoleContinue, consoleMaintReturnN} = 2'h1;
    endtask

    // main sequence
    initial
    begin
        err_count = 0;
        check_count = 0;
        {resetn, powerGood, microTrap, initRequest, cacheStall, patchRequest} = 6'h00;
        {consoleBreakEnable, consoleContinue, consoleTrapToWritable} = 3'h0;
        {consoleMaintReturnN, consoleForceNoopN} = 2'h3;
        {branchCond, decisionPointAddr, patchAddr} = 24'h000000;
        controlWord = 80'h0123;
        trapVector = 4'h5;
        csPresence = 8'hA5;
        repeat (10) @(negedge mclk);
        resetn = 1'b1;
        t_power;
        t_trap;
        t_noop;
        t_regs;
        t_wcs;
        t_stack;
        t_break;
        wrap_up;
    end

    // watchdog, about twenty-five times the expected run
    initial
    begin
        #100000;
        err_count = err_count + 1;
        wrap_up;
    end
endmodule // mseq_next_address_tb

/* File: rtl/mseq_next_address.v */
`timescale 1ns/1ps
`include "mseq_regs.vh"

// Function
// - five-bit branch field at 76..72 selects none, 8, 16 or 32-way branch.
// - bus push decrements stack pointer first, then stores bus bits 15..0.
// - bus pop gives the addressed stack word, then increments the pointer.
// - call decrements pointer, pushes saved PC; fields choose subroutine start.
// - return ORs stack top with jump and branch bits, then increments pointer.
// - while power is bad stay in initialize, driving a constant trap vector.
// - maintenance return takes next address from stack, then increments pointer.
// - data register read gives presence in bits 7..0, zeros above.
// - break match when break register equals next address; scope sync at 150.
// - with console enable, break match stops clock at start of matched cycle.
// - console trap-to-writable forces PC bit 12 high during traps.
// - console force no-op asserts clear-word and abort-cycle outputs.
// - register widths 16, 13, 16, data 32 write, 8 read, low bits.
// - bus addresses 20..23 hex are stack, break, store address, store data.
// - word count 11 is load-only and blocks data writes and increments.
// - count wrap from 10 to 00 increments store address bits 12..0.
// - word count advances after every data write to fill higher groups.
// - stack output registered at cycle start and held until the next.
// - cycle-start flops; priority init, maint return, stall, trap, patch, normal.
// - during maintenance return, stack writes from trap or push are inhibited.
// - mux enabled at 50, latch closes 125, mux off 150, latch opens 50.
// - subroutine field 65..64: none, call, return, decision point branch.
// - jump field bits 12..0 forms the base of the next address.
module mseq_next_address (
    // clock and reset
    input  wire        mclk,
    input  wire        resetn,
    // current control word and branch sources
    input  wire [79:0] controlWord,
    input  wire [4:0]  branchCond,
    input  wire [12:0] decisionPointAddr,
    // condition requests from processor logic
    input  wire        initRequest,
    input  wire        cacheStall,
    input  wire        microTrap,
    input  wire [3:0]  trapVector,
    input  wire        patchRequest,
    input  wire [5:0]  patchAddr,
    // pins from power and console
    input  wire        powerGood,
    input  wire        consoleMaintReturnN,
    input  wire        consoleTrapToWritable,
    input  wire        consoleForceNoopN,
    input  wire        consoleBreakEnable,
    input  wire        consoleContinue,
    // control store module presence
    input  wire [7:0]  csPresence,
    // internal data bus
    input  wire        idStrobe,
    input  wire [5:0]  idAddr,
    input  wire        idWrite,
    input  wire [31:0] idDataIn,
    output reg  [31:0] idDataOut_q,
    output reg         idDataValid_q,
    // micro PC and latch timing
    output reg  [12:0] microPc_q,
    output reg  [12:0] microPcSave_q,
    output reg         muxOutEnable_q,
    output reg         latchClosed_q,
    // cycle control
    output reg         clearMicroWord_q,
    output reg         abortCycle_q,
    output reg         breakMatch_q,
    output reg         scopeSync_q,
    output reg         clockStopped_q,
    // writable control store write port
    output reg         csWrEn_q,
    output reg  [12:0] csWrAddr_q,
    output reg  [1:0]  csWrGroup_q,
    output reg  [31:0] csWrData_q
);

    // next-address source selects
    localparam SRC_INIT   = 3'h0;
    localparam SRC_MAINT  = 3'h1;
    localparam SRC_STALL  = 3'h2;
    localparam SRC_TRAP   = 3'h3;
    localparam SRC_PATCH  = 3'h4;
    localparam SRC_NORMAL = 3'h5;

    // low address bits contributed by the branch field
    function [12:0] branchBits;
        input [4:0] ben;
        input [4:0] cond;
        begin
            if (ben == `MSEQ_BEN_NONE)
                branchBits = 13'h0000;
            else if (ben <= `MSEQ_BEN_8WAY_MAX)
                branchBits = {10'h000, cond[2:0]};
            else if (ben <= `MSEQ_BEN_16WAY_MAX)
                branchBits = {9'h000, cond[3:0]};
            else
                branchBits = {8'h00, cond};
        end
    endfunction

    // modulo-3 word count step
    function [1:0] countStep;
        input [1:0] cnt;
        begin
            if (cnt == `MSEQ_CNT_WRAP)
                countStep = 2'h0;
            else
                countStep = cnt + 2'h1;
        end
    endfunction

    reg  [5:0]  pinMeta_q;
    reg  [5:0]  pinSync_q;
    reg         contPrev_q;
    reg         initCond_q;
    reg         initPrev_q;
    reg         maint_q;
    reg         stall_q;
    reg         trap_q;
    reg         patch_q;
    reg  [3:0]  trapVec_q;
    reg  [5:0]  patchAddr_q;
    reg  [15:0] stackTop_q;
    reg  [3:0]  stackPtr_q;
    reg  [12:0] breakReg_q;
    reg  [15:0] csAddr_q;
    reg  [1:0]  readSel_q;
    reg         readPend_q;
    reg  [2:0]  srcSel;
    reg  [12:0] nextAddr;
    wire [4:0]  phase;
    wire [15:0] stackRdData;
    wire        powerOk;
    wire        maintReturn;
    wire        trapToWritable;
    wire        forceNoop;
    wire        breakEnable;
    wire        contEdge;
    wire        cptStart;
    wire        cpt125Tick;
    wire        initActive;
    wire [4:0]  benField;
    wire [1:0]  subField;
    wire [12:0] jumpField;
    wire [12:0] fieldAddr;
    wire        stackSlot;
    wire        seqPush;
    wire        seqPop;
    wire        idPush;
    wire        idPop;
    wire        memWrEn;
    wire [15:0] memWrData;
    wire        csDataWrite;
    wire        breakMatchNow;

    // power and console pins pass two flops before use
    always @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            pinMeta_q  <= 6'h0A;
            pinSync_q  <= 6'h0A;
            contPrev_q <= 1'b0;
        end
        else
        begin
            pinMeta_q  <= {consoleContinue, consoleBreakEnable, consoleForceNoopN,
                           consoleTrapToWritable, consoleMaintReturnN, powerGood};
            pinSync_q  <= pinMeta_q;
            contPrev_q <= pinSync_q[5];
        end
    end

    assign powerOk        = pinSync_q[0];
    assign maintReturn    = ~pinSync_q[1];
    assign trapToWritable = pinSync_q[2];
    assign forceNoop      = ~pinSync_q[3];
    assign breakEnable    = pinSync_q[4];
    assign contEdge       = pinSync_q[5] & ~contPrev_q;

    mseq_phase_gen u_phase (
        .mclk    (mclk),
        .resetn  (resetn),
        .hold    (clockStopped_q),
        .phase_q (phase)
    );

    assign cptStart   = (phase == 5'h00);
    assign cpt125Tick = (phase == `MSEQ_CPT125_CLKS) && !clockStopped_q;

    // control word fields
    assign benField  = controlWord[`MSEQ_BEN_HI:`MSEQ_BEN_LO];
    assign subField  = controlWord[`MSEQ_SUB_HI:`MSEQ_SUB_LO];
    assign jumpField = controlWord[`MSEQ_JUMP_HI:0];
    assign fieldAddr = jumpField | branchBits(benField, branchCond);

    // condition flops sample at cycle start, init held one extra cycle
    always @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            initCond_q  <= 1'b1;
            initPrev_q  <= 1'b1;
            maint_q     <= 1'b0;
            stall_q     <= 1'b0;
            trap_q      <= 1'b0;
            patch_q     <= 1'b0;
            trapVec_q   <= 4'h0;
            patchAddr_q <= 6'h00;
        end
        else if (cptStart)
        begin
            initCond_q  <= initRequest | ~powerOk;
            initPrev_q  <= initCond_q;
            maint_q     <= maintReturn;
            stall_q     <= cacheStall;
            trap_q      <= microTrap;
            patch_q     <= patchRequest;
            trapVec_q   <= trapVector;
            patchAddr_q <= patchAddr;
        end
    end

    assign initActive = initCond_q | initPrev_q;

    // priority of held conditions
    always @*
    begin
        if (initActive)
            srcSel = SRC_INIT;
        else if (maint_q)
            srcSel = SRC_MAINT;
        else if (stall_q)
            srcSel = SRC_STALL;
        else if (trap_q)
            srcSel = SRC_TRAP;
        else if (patch_q)
            srcSel = SRC_PATCH;
        else
            srcSel = SRC_NORMAL;
    end

    // next micro address per selected source
    always @*
    begin
        case (srcSel)
            SRC_INIT:   nextAddr = `MSEQ_TRAP_BASE;
            SRC_MAINT:  nextAddr = stackTop_q[12:0];
            SRC_STALL:  nextAddr = microPcSave_q;
            SRC_TRAP:   nextAddr = `MSEQ_TRAP_BASE | {9'h000, trapVec_q};
            SRC_PATCH:  nextAddr = `MSEQ_PATCH_BASE | {7'h00, patchAddr_q};
            SRC_NORMAL:
            begin
                case (subField)
                    `MSEQ_SUB_RETURN: nextAddr = stackTop_q[12:0] | fieldAddr;
                    `MSEQ_SUB_DPB:    nextAddr = decisionPointAddr;
                    default:          nextAddr = fieldAddr;
                endcase
            end
            default:    nextAddr = `MSEQ_TRAP_BASE;
        endcase
        if ((srcSel == SRC_INIT || srcSel == SRC_TRAP) && trapToWritable)
            nextAddr[`MSEQ_WCS_BIT] = 1'b1;
    end

    // stack traffic: sequencer owns the 125 slot, bus requests there are dropped
    assign stackSlot = idStrobe && (idAddr == `MSEQ_ADDR_STACK) && !cpt125Tick;
    assign seqPush   = cpt125Tick && !maint_q &&
                       ((srcSel == SRC_TRAP) ||
                        (srcSel == SRC_NORMAL && subField == `MSEQ_SUB_CALL));
    assign seqPop    = cpt125Tick &&
                       ((srcSel == SRC_MAINT) ||
                        (srcSel == SRC_NORMAL && subField == `MSEQ_SUB_RETURN));
    assign idPush    = stackSlot && idWrite && !maint_q;
    assign idPop     = stackSlot && !idWrite;
    assign memWrEn   = seqPush | idPush;
    assign memWrData = idPush ? idDataIn[15:0] : {3'h0, microPcSave_q};

    mseq_stack_mem u_stack (
        .mclk     (mclk),
        .resetn   (resetn),
        .wrEn     (memWrEn),
        .wrAddr   (stackPtr_q - 4'h1),
        .wrData   (memWrData),
        .rdAddr   (stackPtr_q),
        .rdData_q (stackRdData)
    );

    // stack pointer: decrement with write, increment after read
    always @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            stackPtr_q <= `MSEQ_SP_RESET;
        else if (initActive)
            stackPtr_q <= `MSEQ_SP_RESET;
        else if (memWrEn)
            stackPtr_q <= stackPtr_q - 4'h1;
        else if (seqPop || idPop)
            stackPtr_q <= stackPtr_q + 4'h1;
    end

    // stack top captured at cycle start and held through the cycle
    always @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            stackTop_q <= 16'h0000;
        else if (cptStart)
            stackTop_q <= stackRdData;
    end

    // micro PC latch and save register
    always @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            microPc_q     <= `MSEQ_TRAP_BASE;
            microPcSave_q <= `MSEQ_TRAP_BASE;
        end
        else
        begin
            if (cpt125Tick)
                microPc_q <= nextAddr;
            if (cptStart && !(microTrap && trapVector == `MSEQ_PARITY_VEC))
                microPcSave_q <= microPc_q;
        end
    end

    // mux drive window and latch hold window
    always @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            muxOutEnable_q <= 1'b0;
            latchClosed_q  <= 1'b1;
        end
        else
        begin
            muxOutEnable_q <= (phase >= `MSEQ_CPT50_CLKS) &&
                              (phase < `MSEQ_CPT150_CLKS);
            latchClosed_q  <= (phase >= `MSEQ_CPT125_CLKS) ||
                              (phase < `MSEQ_CPT50_CLKS);
        end
    end

    // no-op controls for traps, stalls, patches, init and console
    always @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            clearMicroWord_q <= 1'b1;
            abortCycle_q     <= 1'b1;
        end
        else
        begin
            clearMicroWord_q <= initActive | stall_q | trap_q | patch_q |
                                forceNoop;
            abortCycle_q     <= initActive | trap_q | forceNoop;
        end
    end

    assign breakMatchNow = (breakReg_q == nextAddr);

    // break match, scope sync and clock stop
    always @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            breakMatch_q   <= 1'b0;
            scopeSync_q    <= 1'b0;
            clockStopped_q <= 1'b0;
        end
        else
        begin
            breakMatch_q <= breakMatchNow;
            scopeSync_q  <= breakMatchNow &&
                            (phase == `MSEQ_CPT150_CLKS);
            if (breakEnable && breakMatchNow &&
                (phase == (`MSEQ_CYCLE_CLKS - 1)))
                clockStopped_q <= 1'b1;
            else if (contEdge)
                clockStopped_q <= 1'b0;                      // stop wins over continue
        end
    end

    assign csDataWrite = idStrobe && idWrite && (idAddr == `MSEQ_ADDR_CSDATA) &&
                         (csAddr_q[`MSEQ_CNT_HI:`MSEQ_CNT_LO] != `MSEQ_CNT_INVALID);

    // bus writes of break and store address, store data write sequencing
    always @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            breakReg_q  <= `MSEQ_BREAK_RESET;
            csAddr_q    <= `MSEQ_CSADDR_RESET;
            csWrEn_q    <= 1'b0;
            csWrAddr_q  <= 13'h0000;
            csWrGroup_q <= 2'h0;
            csWrData_q  <= 32'h00000000;
        end
        else
        begin
            csWrEn_q <= csDataWrite;
            if (idStrobe && idWrite && idAddr == `MSEQ_ADDR_BREAK)
                breakReg_q <= idDataIn[12:0];
            if (idStrobe && idWrite && idAddr == `MSEQ_ADDR_CSADDR)
                csAddr_q <= idDataIn[15:0];
            else if (csDataWrite)
            begin
                csWrAddr_q  <= csAddr_q[12:0];
                csWrGroup_q <= csAddr_q[`MSEQ_CNT_HI:`MSEQ_CNT_LO];
                csWrData_q  <= idDataIn;
                csAddr_q[`MSEQ_CNT_HI:`MSEQ_CNT_LO] <=
                    countStep(csAddr_q[`MSEQ_CNT_HI:`MSEQ_CNT_LO]);
                if (csAddr_q[`MSEQ_CNT_HI:`MSEQ_CNT_LO] == `MSEQ_CNT_WRAP)
                    csAddr_q[12:0] <= csAddr_q[12:0] + 13'h0001;
            end
        end
    end

    // read request capture, answer one clock later
    always @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            readPend_q <= 1'b0;
            readSel_q  <= 2'h0;
        end
        else
        begin
            readPend_q <= idStrobe && !idWrite && (idAddr[5:2] == 4'h8) &&
                          !(idAddr == `MSEQ_ADDR_STACK && cpt125Tick);
            readSel_q  <= idAddr[1:0];
        end
    end

    // read data, low bits carry the register, upper bits zero
    always @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            idDataOut_q   <= 32'h00000000;
            idDataValid_q <= 1'b0;
        end
        else
        begin
            idDataValid_q <= readPend_q;
            if (readPend_q)
            begin
                case (readSel_q)
                    2'h0:    idDataOut_q <= {16'h0000, stackRdData};
                    2'h1:    idDataOut_q <= {19'h00000, breakReg_q};
                    2'h2:    idDataOut_q <= {16'h0000, csAddr_q};
                    default: idDataOut_q <= {24'h000000, csPresence};
                endcase
            end
        end
    end

endmodule // mseq_next_address

/* File: rtl/mseq_phase_gen.v */
`timescale 1ns/1ps
`include "mseq_regs.vh"

module mseq_phase_gen (
    // clock and reset
    input  wire       mclk,
    input  wire       resetn,
    // hold at cycle start while the processor clock is stopped
    input  wire       hold,
    // phase count within the machine cycle
    output reg  [4:0] phase_q
);

    // counts clocks across one machine cycle, parks at zero when held
    always @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            phase_q <= 5'h00;
        else if (hold && (phase_q == 5'h00))
            phase_q <= 5'h00;
        else if (phase_q == (`MSEQ_CYCLE_CLKS - 1))
            phase_q <= 5'h00;
        else
            phase_q <= phase_q + 5'h01;
    end

endmodule // mseq_phase_gen

/* File: rtl/mseq_regs.vh */
`ifndef MSEQ_REGS_VH
`define MSEQ_REGS_VH

// internal bus register addresses
`define MSEQ_ADDR_STACK      6'h20
`define MSEQ_ADDR_BREAK      6'h21
`define MSEQ_ADDR_CSADDR     6'h22
`define MSEQ_ADDR_CSDATA     6'h23

// machine cycle timing, figures in ns
`define MSEQ_CLK_NS          10
`define MSEQ_CYCLE_NS        200
`define MSEQ_CPT50_NS        50
`define MSEQ_CPT125_NS       125
`define MSEQ_CPT150_NS       150

// phase points as clock counts from cycle start, least times rounded up
`define MSEQ_CYCLE_CLKS      (`MSEQ_CYCLE_NS / `MSEQ_CLK_NS)
`define MSEQ_CPT50_CLKS      ((`MSEQ_CPT50_NS + `MSEQ_CLK_NS - 1) / `MSEQ_CLK_NS)
`define MSEQ_CPT125_CLKS     ((`MSEQ_CPT125_NS + `MSEQ_CLK_NS - 1) / `MSEQ_CLK_NS)
`define MSEQ_CPT150_CLKS     ((`MSEQ_CPT150_NS + `MSEQ_CLK_NS - 1) / `MSEQ_CLK_NS)

// control word field positions
`define MSEQ_BEN_HI          76
`define MSEQ_BEN_LO          72
`define MSEQ_SUB_HI          65
`define MSEQ_SUB_LO          64
`define MSEQ_JUMP_HI         12

// subroutine field codes
`define MSEQ_SUB_NONE        2'h0
`define MSEQ_SUB_CALL        2'h1
`define MSEQ_SUB_RETURN      2'h2
`define MSEQ_SUB_DPB         2'h3

// branch enable ranges
`define MSEQ_BEN_NONE        5'h00
`define MSEQ_BEN_8WAY_MAX    5'h0F
`define MSEQ_BEN_16WAY_MAX   5'h1B

// addresses and control store address register layout
`define MSEQ_TRAP_BASE       13'h0100
`define MSEQ_PATCH_BASE      13'h1000
`define MSEQ_WCS_BIT         12
`define MSEQ_CNT_HI          15
`define MSEQ_CNT_LO          14
`define MSEQ_CNT_WRAP        2'h2
`define MSEQ_CNT_INVALID     2'h3
`define MSEQ_PARITY_VEC      4'hF

// reset values
`define MSEQ_SP_RESET        4'h0
`define MSEQ_BREAK_RESET     13'h0000
`define MSEQ_CSADDR_RESET    16'h0000

`endif

/* File: rtl/mseq_stack_mem.v */
`timescale 1ns/1ps

module mseq_stack_mem (
    // clock and reset
    input  wire        mclk,
    input  wire        resetn,
    // write port
    input  wire        wrEn,
    input  wire [3:0]  wrAddr,
    input  wire [15:0] wrData,
    // registered read port
    input  wire [3:0]  rdAddr,
    output reg  [15:0] rdData_q
);

    reg [15:0] mem [0:15];

    // storage has no reset, only its read register does
    always @(posedge mclk)
    begin
        if (wrEn)
            mem[wrAddr] <= wrData;
    end

    // read happens every clock, old data on a same-address write
    always @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            rdData_q <= 16'h0000;
        else
            rdData_q <= mem[rdAddr];
    end

endmodule // mseq_stack_mem
